/* rtl/dcc_chain.sv */
// Completion-chaining event sequencer of a multi-channel DMA channel controller.
// Assumes an outside transfer engine that moves one request at a time and pulses XFER_DONE,
// and an Avalon-MM master for the registers.
//
// Behaviour
// - A non-final array completion with intermediate chaining on sets the chained flag named by its code.
// - A final array completion chains through the final chaining enable into the flag named by its code.
// - Completion with its interrupt enable sets the pending flag of its code, signalled only when unmasked.
// - Each chained event makes the target channel move its next array, or its next frame in frame-synchronized mode, until its counts run out.
// - A completion code equal to the channel's own number re-triggers the same channel.
// - With final interrupt on a self-chained channel, the interrupt comes only after the last array.
// - In array-synchronized mode one event moves exactly one array of the first-dimension byte count.
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/100ps

module dcc_chain
  import dcc_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [NUM_CH-1:0] EXTERNAL_EVENT_PIN,
  output logic XFER_START,
  output logic [CW-1:0] XFER_CHANNEL,
  output logic [31:0] XFER_BYTES,
  input wire logic XFER_DONE,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // State and bus helpers
  // ----------------------------------------------------------------
  dcc_regs_s s_q;
  dcc_regs_s s_d;
  logic bus_req;
  logic wr_go;
  logic [31:0] bmask;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic [NUM_CH-1:0] pend;
  logic [CW-1:0] pick;
  logic [CW-1:0] code;
  logic last_arr;
  logic [31:0] cnt_word;
  logic [OPT_W-1:0] sel_opt;

  // Byte-lane mask, request qualifiers and channel decodes
  assign bmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}}, {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign wmask = AVS_WRITEDATA & bmask;
  assign bus_req = AVS_READ | AVS_WRITE;
  assign wr_go = AVS_WRITE & s_q.ack;
  assign pend = s_q.evt | s_q.chain;
  assign sel_opt = s_q.channel_options[s_q.sel];
  assign code = s_q.channel_options[s_q.cur][OPT_CODE_LSB +: CW];
  assign last_arr = (s_q.left[s_q.cur] == 32'h0000_0001);

  // Read data selection for the addressed register
  always_comb begin
    case (AVS_ADDRESS)
      ADR_EVT_SET: rd_mux = s_q.evt;
      ADR_CHAIN: rd_mux = s_q.chain;
      ADR_EVT_EN: rd_mux = s_q.evt_en;
      ADR_IRQ_PEND: rd_mux = s_q.ipend;
      ADR_IRQ_EN: rd_mux = s_q.ien;
      ADR_CH_SEL: rd_mux = {27'h0000000, s_q.sel};
      ADR_CH_OPT: rd_mux = {21'h000000, sel_opt};
      ADR_CH_CNT: rd_mux = {s_q.second_dim_count[s_q.sel], s_q.first_dim_count[s_q.sel]};
      ADR_CH_CNT3: rd_mux = {16'h0000, s_q.third_dim_count[s_q.sel]};
      ADR_CH_LEFT: rd_mux = s_q.left[s_q.sel];
      ADR_STATUS: rd_mux = {23'h000000, (s_q.state == ST_WAIT), 3'h0, s_q.cur};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Lowest pending channel wins the dispatch
  always_comb begin
    pick = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick = CW'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    cnt_word = 32'h0000_0000;
    s_d.xfer_start = 1'b0;
    // One wait cycle per access, read data latched in the first
    s_d.ack = bus_req & ~s_q.ack;
    if (AVS_READ & ~s_q.ack) begin
      s_d.rdata = rd_mux;
    end

    // Dispatch: consume the event, skip channels with no arrays left
    if (s_q.state == ST_IDLE && pend != '0) begin
      s_d.evt[pick] = 1'b0;
      s_d.chain[pick] = 1'b0;
      if (s_q.left[pick] != 32'h0000_0000) begin
        s_d.cur = pick;
        s_d.xfer_start = 1'b1;
        s_d.state = ST_WAIT;
        if (s_q.channel_options[pick][OPT_SYNC_DIM]) begin
          s_d.xfer_bytes = {16'h0000, s_q.first_dim_count[pick]} * {16'h0000, s_q.second_dim_count[pick]};
        end else begin
          s_d.xfer_bytes = {16'h0000, s_q.first_dim_count[pick]};
        end
      end
    end

    // Register writes, clears applied before hardware sets
    if (wr_go) begin
      case (AVS_ADDRESS)
        ADR_EVT_SET: begin
          s_d.evt = s_d.evt | wmask;
        end
        ADR_CHAIN: begin
          s_d.chain = s_d.chain & ~wmask;
        end
        ADR_EVT_EN: begin
          s_d.evt_en = (s_q.evt_en & ~bmask) | wmask;
        end
        ADR_IRQ_PEND: begin
          s_d.ipend = s_q.ipend & ~wmask;
        end
        ADR_IRQ_EN: begin
          s_d.ien = (s_q.ien & ~bmask) | wmask;
        end
        ADR_CH_SEL: begin
          cnt_word = ({27'h0000000, s_q.sel} & ~bmask) | wmask;
          s_d.sel = cnt_word[CW-1:0];
        end
        ADR_CH_OPT: begin
          cnt_word = ({21'h000000, sel_opt} & ~bmask) | wmask;
          s_d.channel_options[s_q.sel] = cnt_word[OPT_W-1:0];
        end
        ADR_CH_CNT: begin
          cnt_word = ({s_q.second_dim_count[s_q.sel], s_q.first_dim_count[s_q.sel]} & ~bmask) | wmask;
          s_d.first_dim_count[s_q.sel] = cnt_word[CNT_W-1:0];
          s_d.second_dim_count[s_q.sel] = cnt_word[CNT_B_LSB +: CNT_W];
        end
        // Writing the third count arms the channel
        ADR_CH_CNT3: begin
          cnt_word = ({16'h0000, s_q.third_dim_count[s_q.sel]} & ~bmask) | wmask;
          s_d.third_dim_count[s_q.sel] = cnt_word[CNT_W-1:0];
          if (sel_opt[OPT_SYNC_DIM]) begin
            s_d.left[s_q.sel] = {16'h0000, cnt_word[CNT_W-1:0]};
          end else begin
            s_d.left[s_q.sel] = {16'h0000, s_q.second_dim_count[s_q.sel]} * {16'h0000, cnt_word[CNT_W-1:0]};
          end
        end
        default: begin
        end
      endcase
    end

    s_d.evt = s_d.evt | (EXTERNAL_EVENT_PIN & s_q.evt_en);

    // Completion handling
    case (s_q.state)
      ST_WAIT: begin
        if (XFER_DONE) begin
          s_d.left[s_q.cur] = s_q.left[s_q.cur] - 32'h0000_0001;
          s_d.state = ST_IDLE;
          if (last_arr) begin
            if (s_q.channel_options[s_q.cur][OPT_FIN_CHAIN]) begin
              s_d.chain[code] = 1'b1;
            end
            if (s_q.channel_options[s_q.cur][OPT_FIN_IRQ]) begin
              s_d.ipend[code] = 1'b1;
            end
          end else begin
            if (s_q.channel_options[s_q.cur][OPT_INT_CHAIN]) begin
              s_d.chain[code] = 1'b1;
            end
            if (s_q.channel_options[s_q.cur][OPT_INT_IRQ]) begin
              s_d.ipend[code] = 1'b1;
            end
          end
        end
      end
      ST_IDLE: begin
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q.evt <= RST_FLAGS;
      s_q.chain <= RST_FLAGS;
      s_q.evt_en <= RST_FLAGS;
      s_q.ipend <= RST_FLAGS;
      s_q.ien <= RST_FLAGS;
      s_q.sel <= '0;
      s_q.channel_options <= {NUM_CH{RST_OPT}};
      s_q.first_dim_count <= {NUM_CH{RST_CNT}};
      s_q.second_dim_count <= {NUM_CH{RST_CNT}};
      s_q.third_dim_count <= {NUM_CH{RST_CNT}};
      s_q.left <= {NUM_CH{32'h0000_0000}};
      s_q.state <= ST_IDLE;
      s_q.cur <= '0;
      s_q.ack <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
      s_q.xfer_start <= 1'b0;
      s_q.xfer_bytes <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign AVS_WAITREQUEST = bus_req & ~s_q.ack;
  assign AVS_READDATA = s_q.rdata;
  assign XFER_START = s_q.xfer_start;
  assign XFER_CHANNEL = s_q.cur;
  assign XFER_BYTES = s_q.xfer_bytes;
  assign IRQ = |(s_q.ipend & s_q.ien);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // One wait cycle per access
  chk_bus_answer: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (bus_req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
    else $error("bus access not answered after one wait cycle");

  chk_inter_chain: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (s_q.state == ST_WAIT && XFER_DONE && !last_arr && s_q.channel_options[s_q.cur][OPT_INT_CHAIN])
    |=> s_q.chain[$past(code)])
    else $error("intermediate chain flag not set");

  chk_final_chain: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (s_q.state == ST_WAIT && XFER_DONE && last_arr && s_q.channel_options[s_q.cur][OPT_FIN_CHAIN])
    |=> s_q.chain[$past(code)] && s_q.state == ST_IDLE)
    else $error("final chain flag not set");

  chk_final_irq: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (s_q.state == ST_WAIT && XFER_DONE && last_arr && s_q.channel_options[s_q.cur][OPT_FIN_IRQ] && s_q.ien[code])
    |=> s_q.ipend[$past(code)] && IRQ)
    else $error("final interrupt not raised");

  chk_chain_serve: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (s_q.state == ST_IDLE && s_q.chain[pick] && s_q.left[pick] != 32'h0000_0000)
    |=> XFER_START && XFER_CHANNEL == $past(pick) ##1 !XFER_START)
    else $error("chained event did not start next array");

  chk_self_retrig: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (s_q.state == ST_WAIT && XFER_DONE && !last_arr && s_q.channel_options[s_q.cur][OPT_INT_CHAIN]
     && code == s_q.cur && pend == '0 && EXTERNAL_EVENT_PIN == '0 && !AVS_WRITE)
    |-> ##2 XFER_START && XFER_CHANNEL == $past(s_q.cur, 2))
    else $error("self chained channel not re-triggered");

  chk_no_early_irq: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (s_q.state == ST_WAIT && XFER_DONE && !last_arr && !s_q.channel_options[s_q.cur][OPT_INT_IRQ])
    |=> (s_q.ipend & ~$past(s_q.ipend)) == '0)
    else $error("interrupt raised before last array");

  chk_array_bytes: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (XFER_START && !s_q.channel_options[s_q.cur][OPT_SYNC_DIM]) |-> XFER_BYTES == {16'h0000, s_q.first_dim_count[s_q.cur]})
    else $error("array sync moved other than one array");

  chk_pend_sticky: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !(wr_go && AVS_ADDRESS == ADR_IRQ_PEND) |=> ($past(s_q.ipend) & ~s_q.ipend) == '0)
    else $error("pending flag dropped without software clear");

  chk_evt_gate: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    !wr_go |=> (s_q.evt & ~$past(s_q.evt) & ~$past(s_q.evt_en)) == '0)
    else $error("disabled external event was taken");

  chk_evt_consume: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (s_q.state == ST_IDLE && pend != '0)
    |=> !s_q.chain[$past(pick)])
    else $error("dispatched chain flag not consumed");

  chk_empty_skip: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (s_q.state == ST_IDLE && pend != '0 && s_q.left[pick] == 32'h0000_0000)
    |=> !XFER_START && s_q.state == ST_IDLE)
    else $error("channel with no arrays left was started");

  chk_last_empty: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (s_q.state == ST_WAIT && XFER_DONE && last_arr)
    |=> s_q.left[s_q.cur] == 32'h0000_0000)
    else $error("arrays left after the last array");

  chk_frame_bytes: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (XFER_START && s_q.channel_options[s_q.cur][OPT_SYNC_DIM])
    |-> XFER_BYTES == {16'h0000, s_q.first_dim_count[s_q.cur]} * {16'h0000, s_q.second_dim_count[s_q.cur]})
    else $error("frame sync moved other than one frame");

  chk_start_pulse: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    XFER_START |=> !XFER_START)
    else $error("transfer request longer than one cycle");

  chk_inter_irq: assert property (@(posedge REF_CLK) disable iff (!ARST_N)
    (s_q.state == ST_WAIT && XFER_DONE && !last_arr && s_q.channel_options[s_q.cur][OPT_INT_IRQ])
    |=> s_q.ipend[$past(code)])
    else $error("intermediate interrupt not pending");

endmodule

/* rtl/dcc_pkg.sv */
// Constants, state codes and the state record of the completion-chaining block.
// Assumes a 32-channel controller with one 32-bit flag bit per channel.
package dcc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 32;
  localparam int CW = 5;
  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_EVT_SET = 8'h00;
  localparam logic [7:0] ADR_CHAIN = 8'h04;
  localparam logic [7:0] ADR_EVT_EN = 8'h08;
  localparam logic [7:0] ADR_IRQ_PEND = 8'h0C;
  localparam logic [7:0] ADR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADR_CH_SEL = 8'h14;
  localparam logic [7:0] ADR_CH_OPT = 8'h18;
  localparam logic [7:0] ADR_CH_CNT = 8'h1C;
  localparam logic [7:0] ADR_CH_CNT3 = 8'h20;
  localparam logic [7:0] ADR_CH_LEFT = 8'h24;
  localparam logic [7:0] ADR_STATUS = 8'h28;

  // ----------------------------------------------------------------
  // Channel options, count and status field layout
  // ----------------------------------------------------------------
  localparam int OPT_W = 11;
  localparam int OPT_CODE_LSB = 0;
  localparam int OPT_CODE_MODE = 5;
  localparam int OPT_SYNC_DIM = 6;
  localparam int OPT_FIN_IRQ = 7;
  localparam int OPT_INT_IRQ = 8;
  localparam int OPT_FIN_CHAIN = 9;
  localparam int OPT_INT_CHAIN = 10;
  localparam int CNT_B_LSB = 16;
  localparam int STAT_BUSY = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
  localparam logic [OPT_W-1:0] RST_OPT = 11'h000;
  localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;

  // ----------------------------------------------------------------
  // Sequencer states and state record
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } dcc_state_e;

  typedef struct packed {
    logic [NUM_CH-1:0] evt;
    logic [NUM_CH-1:0] chain;
    logic [NUM_CH-1:0] evt_en;
    logic [NUM_CH-1:0] ipend;
    logic [NUM_CH-1:0] ien;
    logic [CW-1:0] sel;
    logic [NUM_CH-1:0][OPT_W-1:0] channel_options;
    logic [NUM_CH-1:0][CNT_W-1:0] first_dim_count;
    logic [NUM_CH-1:0][CNT_W-1:0] second_dim_count;
    logic [NUM_CH-1:0][CNT_W-1:0] third_dim_count;
    logic [NUM_CH-1:0][31:0] left;
    dcc_state_e state;
    logic [CW-1:0] cur;
    logic ack;
    logic [31:0] rdata;
    logic xfer_start;
    logic [31:0] xfer_bytes;
  } dcc_regs_s;

endpackage

/* sim/dcc_chain_tb.sv */
// Self-checking bench of the completion-chaining block.
// Assumes the transfer engine model beside it; the bench is the bus master and event source.
`timescale 1ns/100ps

module dcc_chain_tb;
  import dcc_pkg::*;
  logic ref_clk, arst_n, avs_read, avs_write, avs_waitrequest, xfer_start, xfer_done, irq;
  logic [7:0] avs_address, delay;
  logic [31:0] avs_writedata, avs_readdata, xfer_bytes, ext_pin, rd;
  logic [CW-1:0] xfer_channel;
  int n_mismatch, checks, n_done, n_start, irq_at, cycles;
  int n_ch[NUM_CH];
  logic [31:0] sum[NUM_CH];

  // ----------------------------------------
  // Clock, block and engine
  // ----------------------------------------
  // Free running clock of 50 ns
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  dcc_chain u_dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .EXTERNAL_EVENT_PIN(ext_pin),
    .XFER_START(xfer_start), .XFER_CHANNEL(xfer_channel), .XFER_BYTES(xfer_bytes),
    .XFER_DONE(xfer_done), .IRQ(irq));

  dcc_xfer_model u_eng (.REF_CLK(ref_clk), .ARST_N(arst_n), .XFER_START(xfer_start), .DELAY(delay),
    .XFER_DONE(xfer_done));

  // Counts requests, bytes and completions, notes the first interrupt, cuts a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (xfer_start === 1'b1) begin
      n_start++;
      n_ch[xfer_channel]++;
      sum[xfer_channel] += xfer_bytes;
    end
    if (xfer_done === 1'b1) n_done++;
    if (irq === 1'b1 && irq_at < 0) irq_at = n_done;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= adr;
    avs_writedata <= wd;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Selects a channel, sets options and counts, then arms it
  task automatic cfg(input logic [31:0] ch, input logic [31:0] channel_options, input logic [31:0] cnt);
    bus(1'b1, ADR_CH_SEL, ch);
    bus(1'b1, ADR_CH_OPT, channel_options);
    bus(1'b1, ADR_CH_CNT, cnt);
    bus(1'b1, ADR_CH_CNT3, 32'h0000_0001);
  endtask

  task automatic wait_idle(input int ch, input int n);
    int i;
    i = 0;
    while ((n_ch[ch] < n || n_done != n_start) && i < 2000) begin
      @(posedge ref_clk);
      i++;
    end
    chk(i < 2000, 1'b1);
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic pulse();
    @(posedge ref_clk);
    ext_pin <= 32'h0010_0000;
    @(posedge ref_clk);
    ext_pin <= 32'h0000_0000;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd_chk(ADR_EVT_EN, RST_FLAGS);
    rd_chk(ADR_IRQ_PEND, RST_FLAGS);
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    rd_chk(8'h40, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_self();
    delay <= 8'h05;
    cfg(25, 32'h0000_0499, 32'h0010_0400);
    bus(1'b1, ADR_IRQ_EN, 32'h0200_0000);
    bus(1'b1, ADR_EVT_SET, 32'h0200_0000);
    wait_idle(25, 16);
    chk(n_ch[25], 16);
    chk(sum[25], 32'h0000_4000);
    rd_chk(ADR_IRQ_PEND, 32'h0200_0000);
    chk(irq_at, 16);
    rd_chk(ADR_CH_LEFT, 32'h0000_0000);
    bus(1'b1, ADR_IRQ_EN, 32'h0000_0000);
    @(negedge ref_clk);
    chk(irq, 1'b0);
    bus(1'b1, ADR_IRQ_EN, 32'h0200_0000);
    @(negedge ref_clk);
    chk(irq, 1'b1);
    bus(1'b1, ADR_IRQ_PEND, 32'h0200_0000);
    @(negedge ref_clk);
    chk(irq, 1'b0);
    rd_chk(ADR_IRQ_PEND, 32'h0000_0000);
    $display("test self_chain done");
  endtask

  task automatic t_pair();
    delay <= 8'h01;
    cfg(20, 32'h0000_0608, 32'h0003_0004);
    cfg(8, 32'h0000_0088, 32'h0003_0002);
    pulse();
    repeat (20) @(posedge ref_clk);
    chk(n_ch[20], 0);
    bus(1'b1, ADR_EVT_EN, 32'h0010_0000);
    for (int k = 1; k <= 3; k++) begin
      pulse();
      wait_idle(8, k);
      chk(n_ch[20], k);
      chk(n_ch[8], k);
    end
    chk(sum[20], 12);
    chk(sum[8], 6);
    rd_chk(ADR_IRQ_PEND, 32'h0000_0100);
    rd_chk(ADR_CHAIN, 32'h0000_0000);
    @(negedge ref_clk);
    chk(irq, 1'b0);
    $display("test pair_chain done");
  endtask

  // Frame sync channel 3: two frames of 3 by 2 bytes, intermediate interrupt to code 5
  task automatic t_frame();
    cfg(3, 32'h0000_0145, 32'h0002_0003);
    bus(1'b1, ADR_CH_CNT3, 32'h0000_0002);
    bus(1'b1, ADR_EVT_SET, 32'h0000_0008);
    wait_idle(3, 1);
    rd_chk(ADR_IRQ_PEND, 32'h0000_0120);
    bus(1'b1, ADR_EVT_SET, 32'h0000_0008);
    wait_idle(3, 2);
    chk(sum[3], 12);
    chk(xfer_bytes, 32'h0000_0006);
    chk(xfer_channel, 32'h0000_0003);
    rd_chk(ADR_CH_LEFT, 32'h0000_0000);
    rd_chk(ADR_STATUS, 32'h0000_0003);
    bus(1'b1, ADR_EVT_SET, 32'h0000_0008);
    repeat (10) @(posedge ref_clk);
    chk(n_ch[3], 2);
    rd_chk(ADR_EVT_SET, 32'h0000_0000);
    rd_chk(ADR_IRQ_PEND, 32'h0000_0120);
    $display("test frame done");
  endtask

  // Unmasks a pending flag, then resets in mid-run
  task automatic t_reset();
    bus(1'b1, ADR_IRQ_EN, 32'h0000_0020);
    @(negedge ref_clk);
    chk(irq, 1'b1);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(negedge ref_clk);
    chk(irq, 1'b0);
    chk(xfer_channel, 32'h0000_0000);
    chk(xfer_bytes, 32'h0000_0000);
    rd_chk(ADR_IRQ_PEND, RST_FLAGS);
    rd_chk(ADR_STATUS, 32'h0000_0000);
    $display("test reset done");
  endtask

  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Resets for 16 cycles, then runs the scenarios
  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    ext_pin = 32'h0000_0000;
    delay = 8'h01;
    irq_at = -1;
    foreach (n_ch[i]) begin
      n_ch[i] = 0;
      sum[i] = 32'h0000_0000;
    end
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_regs();
    t_self();
    t_pair();
    t_frame();
    t_reset();
    final_report();
  end
endmodule

/* sim/dcc_xfer_model.sv */
// Transfer engine model: answers each transfer request with a one-cycle done pulse.
// Assumes one request at a time from the block and a delay of at least one cycle.
`timescale 1ns/100ps

module dcc_xfer_model (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic XFER_START,
  input wire logic [7:0] DELAY,
  output logic XFER_DONE
);
  logic [7:0] cnt_q;

  // ----------------------------------------
  // Delay counter and done pulse
  // ----------------------------------------
  // Loads the delay on a request and pulses done as it runs out
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_q <= 8'h00;
      XFER_DONE <= 1'b0;
    end else begin
      XFER_DONE <= (cnt_q == 8'h01);
      if (XFER_START) begin
        cnt_q <= DELAY;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule
